// [rtl/rru_pkg.sv]
package rru_pkg;

  // Register byte offsets
  localparam logic [4:0] RRU_CTRL_OFS   = 5'h00;
  localparam logic [4:0] RRU_OPND_OFS   = 5'h04;
  localparam logic [4:0] RRU_WORK_OFS   = 5'h08;
  localparam logic [4:0] RRU_INSTR_OFS  = 5'h0c;
  localparam logic [4:0] RRU_STATUS_OFS = 5'h10;
  localparam logic [4:0] RRU_RESULT_OFS = 5'h14;
  localparam logic [4:0] RRU_ADDR_OFS   = 5'h18;

  // Control register fields
  localparam int RRU_CTRL_CARRY_BIT = 0;
  localparam int RRU_CTRL_EXT_BIT   = 1;
  localparam int RRU_CTRL_BANK_LSB  = 8;

  // Status register fields
  localparam int RRU_ST_BUSY_BIT    = 0;
  localparam int RRU_ST_DONE_BIT    = 1;
  localparam int RRU_ST_ILLEGAL_BIT = 2;
  localparam int RRU_ST_INDEXED_BIT = 3;
  localparam int RRU_ST_CARRY_BIT   = 4;
  localparam int RRU_ST_NEG_BIT     = 5;
  localparam int RRU_ST_ZERO_BIT    = 6;

  // Instruction word fields
  localparam int RRU_OPC_LSB  = 10;
  localparam int RRU_DEST_BIT = 9;
  localparam int RRU_ACC_BIT  = 8;

  localparam logic [5:0] RRU_OPC_ROTATE_LEFT_NO_CARRY = 6'h11;
  localparam logic [5:0] RRU_OPC_ROTATE_RIGHT_CARRY   = 6'h0c;
  localparam logic [7:0] RRU_INDEXED_LIMIT            = 8'h5f;
  localparam logic [3:0] RRU_FAST_BANK                = 4'h0;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } rru_phase_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } rru_file_wr_t;

  typedef struct packed {
    rru_phase_t   phase;
    logic         wreq;
    logic [31:0]  rdata;
    logic [15:0]  instr;
    logic [7:0]   opnd;
    logic [7:0]   src;
    logic [7:0]   work;
    logic [7:0]   res;
    logic         carry;
    logic         neg;
    logic         zero;
    logic         ext;
    logic [3:0]   bank;
    logic         illegal;
    logic         indexed;
    logic         done;
    logic [11:0]  addr;
    rru_file_wr_t fwr;
  } rru_state_t;

  localparam rru_state_t RRU_STATE_RESET = '{
    phase: PH_IDLE, wreq: 1'b1, rdata: 32'h0000_0000, instr: 16'h0000,
    opnd: 8'h00, src: 8'h00, work: 8'h00, res: 8'h00,
    carry: 1'b0, neg: 1'b0, zero: 1'b0, ext: 1'b0, bank: 4'h0,
    illegal: 1'b0, indexed: 1'b0, done: 1'b0, addr: 12'h000,
    fwr: '{en: 1'b0, addr: 12'h000, data: 8'h00}
  };

endpackage

// [rtl/rru_rotate_unit.sv]
// Operation
// RQ1: Left rotate, bit7 into bit0, carry kept
// RQ2: Right rotate through carry, bit0 to carry
// RQ3: Dest bit: 0 working reg, 1 file reg
// RQ4: Access bit: 0 fast bank, 1 bank register
// RQ5: Extended, access 0, field<=95: indexed mode
// RQ6: One cycle: decode, read, process, write
// RQ7: Negative is result bit7, zero when result 0
`timescale 1ns/1ps
`default_nettype none
module rru_rotate_unit
  import rru_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // File register write port
  output rru_file_wr_t     file_wr_out
);

  rru_state_t s_reg;
  rru_state_t s_next;

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rot_left(input logic [7:0] v);
    return {v[6:0], v[7]};
  endfunction

  function automatic logic [7:0] rot_right_c(input logic [7:0] v, input logic c);
    return {c, v[7:1]};
  endfunction

  logic [5:0]  opc;
  logic        is_rl;
  logic        is_rr;
  logic        accept;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] merged;

  assign opc   = s_reg.instr[15:RRU_OPC_LSB];
  assign is_rl = (opc == RRU_OPC_ROTATE_LEFT_NO_CARRY);
  assign is_rr = (opc == RRU_OPC_ROTATE_RIGHT_CARRY);
  // Writes stall while an instruction is in flight; reads never do
  assign accept = s_reg.wreq && (avs_read_in || (avs_write_in && s_reg.phase == PH_IDLE));

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[RRU_CTRL_CARRY_BIT] = s_reg.carry;
    ctrl_word[RRU_CTRL_EXT_BIT] = s_reg.ext;
    ctrl_word[RRU_CTRL_BANK_LSB +: 4] = s_reg.bank;
    status_word = 32'h0000_0000;
    status_word[RRU_ST_BUSY_BIT] = (s_reg.phase != PH_IDLE);
    status_word[RRU_ST_DONE_BIT] = s_reg.done;
    status_word[RRU_ST_ILLEGAL_BIT] = s_reg.illegal;
    status_word[RRU_ST_INDEXED_BIT] = s_reg.indexed;
    status_word[RRU_ST_CARRY_BIT] = s_reg.carry;
    status_word[RRU_ST_NEG_BIT] = s_reg.neg;
    status_word[RRU_ST_ZERO_BIT] = s_reg.zero;
  end

  always_comb begin
    s_next = s_reg;
    s_next.fwr.en = 1'b0;
    s_next.wreq = !accept;
    merged = 32'h0000_0000;
    if (accept && avs_read_in) begin
      unique case (avs_address_in)
        RRU_CTRL_OFS:   s_next.rdata = ctrl_word;
        RRU_OPND_OFS:   s_next.rdata = {24'h000000, s_reg.opnd};
        RRU_WORK_OFS:   s_next.rdata = {24'h000000, s_reg.work};
        RRU_INSTR_OFS:  s_next.rdata = {16'h0000, s_reg.instr};
        RRU_STATUS_OFS: s_next.rdata = status_word;
        RRU_RESULT_OFS: s_next.rdata = {24'h000000, s_reg.res};
        RRU_ADDR_OFS:   s_next.rdata = {20'h00000, s_reg.addr};
        default:        s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (!s_reg.wreq && avs_write_in) begin
      unique case (avs_address_in)
        RRU_CTRL_OFS: begin
          merged = merge_be(ctrl_word, avs_writedata_in, avs_byteenable_in);
          s_next.carry = merged[RRU_CTRL_CARRY_BIT];
          s_next.ext = merged[RRU_CTRL_EXT_BIT];
          s_next.bank = merged[RRU_CTRL_BANK_LSB +: 4];
        end
        RRU_OPND_OFS: begin
          merged = merge_be({24'h000000, s_reg.opnd}, avs_writedata_in, avs_byteenable_in);
          s_next.opnd = merged[7:0];
        end
        RRU_WORK_OFS: begin
          merged = merge_be({24'h000000, s_reg.work}, avs_writedata_in, avs_byteenable_in);
          s_next.work = merged[7:0];
        end
        RRU_INSTR_OFS: begin
          merged = merge_be({16'h0000, s_reg.instr}, avs_writedata_in, avs_byteenable_in);
          s_next.instr = merged[15:0];
          s_next.phase = PH_Q1;
          s_next.done = 1'b0;
          s_next.illegal = 1'b0;
        end
        default: begin
        end
      endcase
    end
    unique case (s_reg.phase)
      PH_IDLE: begin
      end
      PH_Q1: begin
        if (is_rl || is_rr) begin
          s_next.phase = PH_Q2;
          s_next.indexed = s_reg.ext && !s_reg.instr[RRU_ACC_BIT]
                           && (s_reg.instr[7:0] <= RRU_INDEXED_LIMIT);   // [RQ5]
          s_next.addr = s_reg.instr[RRU_ACC_BIT] ? {s_reg.bank, s_reg.instr[7:0]}
                                                 : {RRU_FAST_BANK, s_reg.instr[7:0]};   // [RQ4]
        end else begin
          s_next.phase = PH_IDLE;
          s_next.illegal = 1'b1;
        end
      end
      PH_Q2: begin
        s_next.src = s_reg.opnd;   // [RQ6]
        s_next.phase = PH_Q3;
      end
      PH_Q3: begin
        s_next.res = is_rl ? rot_left(s_reg.src)                  // [RQ1]
                           : rot_right_c(s_reg.src, s_reg.carry);  // [RQ2]
        s_next.phase = PH_Q4;
      end
      PH_Q4: begin
        s_next.neg = s_reg.res[7];            // [RQ7]
        s_next.zero = (s_reg.res == 8'h00);   // [RQ7]
        if (is_rr) begin
          s_next.carry = s_reg.src[0];   // [RQ2]
        end
        if (s_reg.instr[RRU_DEST_BIT]) begin
          s_next.opnd = s_reg.res;   // [RQ3]
          s_next.fwr.en = 1'b1;
          s_next.fwr.addr = s_reg.addr;
          s_next.fwr.data = s_reg.res;
        end else begin
          s_next.work = s_reg.res;   // [RQ3]
        end
        s_next.done = 1'b1;
        s_next.phase = PH_IDLE;   // [RQ6]
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s_reg <= RRU_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_out    = s_reg.rdata;
  assign avs_waitrequest_out = s_reg.wreq;
  assign file_wr_out         = s_reg.fwr;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_rl_value: assert property ((s_reg.phase == PH_Q4 && is_rl) |-> s_reg.res == {s_reg.src[6:0], s_reg.src[7]}
                               ##1 s_reg.carry == $past(s_reg.carry)) // [RQ1]
    else $error("left rotate result or carry wrong");
  a_rr_value: assert property ((s_reg.phase == PH_Q4 && is_rr) |-> s_reg.res[6:0] == s_reg.src[7:1]
                               ##1 s_reg.carry == $past(s_reg.src[0])) // [RQ2]
    else $error("right rotate result or carry wrong");
  a_rr_carry_in: assert property ((s_reg.phase == PH_Q2 && is_rr) |-> ##2 s_reg.res[7] == $past(s_reg.carry, 2)) // [RQ2]
    else $error("right rotate did not take old carry");
  a_dest_work: assert property ((s_reg.phase == PH_Q4 && !s_reg.instr[RRU_DEST_BIT])
                                |=> s_reg.work == $past(s_reg.res) && !file_wr_out.en) // [RQ3]
    else $error("working register not written");
  a_dest_file: assert property ((s_reg.phase == PH_Q4 && s_reg.instr[RRU_DEST_BIT])
                                |=> file_wr_out.en && file_wr_out.data == $past(s_reg.res)
                                    && s_reg.opnd == $past(s_reg.res)) // [RQ3]
    else $error("file register not written");
  a_bank_addr: assert property ((s_reg.phase == PH_Q1 && (is_rl || is_rr))
                                |=> s_reg.addr[11:8] == ($past(s_reg.instr[RRU_ACC_BIT]) ? $past(s_reg.bank)
                                                                                        : RRU_FAST_BANK)) // [RQ4]
    else $error("bank selection wrong");
  a_indexed_mode: assert property ((s_reg.phase == PH_Q1 && (is_rl || is_rr))
                                   |=> s_reg.indexed == ($past(s_reg.ext) && !$past(s_reg.instr[RRU_ACC_BIT])
                                                         && ($past(s_reg.instr[7:0]) <= RRU_INDEXED_LIMIT))) // [RQ5]
    else $error("indexed mode flag wrong");
  a_four_phase: assert property ((s_reg.phase == PH_Q1 && (is_rl || is_rr))
                                 |=> s_reg.phase == PH_Q2 ##1 s_reg.phase == PH_Q3
                                     ##1 s_reg.phase == PH_Q4 ##1 s_reg.phase == PH_IDLE) // [RQ6]
    else $error("instruction not four phases");
  a_flags_nz: assert property (s_reg.phase == PH_Q4 |=> s_reg.neg == s_reg.res[7]
                               && s_reg.zero == (s_reg.res == 8'h00)) // [RQ7]
    else $error("negative or zero flag wrong");

  c_rl_to_file: cover property (s_reg.phase == PH_Q4 && is_rl && s_reg.instr[RRU_DEST_BIT]);
  c_rr_to_work: cover property (s_reg.phase == PH_Q4 && is_rr && !s_reg.instr[RRU_DEST_BIT]);
  c_illegal_op: cover property (s_reg.phase == PH_Q1 && !is_rl && !is_rr);
  c_zero_result: cover property (s_reg.phase == PH_Q4 && s_reg.res == 8'h00);

endmodule
`default_nettype wire

// [bench/rru_file_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rru_file_model
  import rru_pkg::*;
(
  // Clock
  input  wire logic         clk_in,
  // File register write port of the core
  input  wire rru_file_wr_t fw_in,
  // Last stored file register
  output logic [11:0]       addr_out,
  output logic [7:0]        data_out
);
  // Register file side: takes each one-cycle write pulse
  always_ff @(posedge clk_in) begin
    if (fw_in.en) begin
      addr_out <= fw_in.addr;
      data_out <= fw_in.data;
    end
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rru_pkg::*;
  typedef struct packed {logic [15:0] ins; logic [7:0] op; logic [1:0] ctl; logic [7:0] res;} rru_row_t;
  localparam rru_row_t ROWS [6] = '{
    '{{RRU_OPC_ROTATE_LEFT_NO_CARRY, 2'b11, 8'h20}, 8'hab, 2'b01, 8'h57},
    '{{RRU_OPC_ROTATE_LEFT_NO_CARRY, 2'b00, 8'h5f}, 8'h00, 2'b10, 8'h00},
    '{{RRU_OPC_ROTATE_RIGHT_CARRY, 2'b00, 8'h60}, 8'he6, 2'b10, 8'h73},
    '{{RRU_OPC_ROTATE_RIGHT_CARRY, 2'b11, 8'h5f}, 8'h01, 2'b00, 8'h00},
    '{{RRU_OPC_ROTATE_RIGHT_CARRY, 2'b10, 8'h10}, 8'h80, 2'b11, 8'hc0},
    '{{RRU_OPC_ROTATE_LEFT_NO_CARRY, 2'b10, 8'h01}, 8'h80, 2'b00, 8'h01}};
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic [4:0]   avs_address = 5'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'hf;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  rru_file_wr_t file_wr;
  logic [11:0]  m_addr;
  logic [7:0]   m_data;
  int           miscompares = 0;
  int           comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  rru_rotate_unit u_dut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .file_wr_out(file_wr));
  rru_file_model u_model (.clk_in(sys_clk), .fw_in(file_wr), .addr_out(m_addr), .data_out(m_data));
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) miscompares++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic run_instr(input logic [15:0] ins);
    int n;
    logic [31:0] q;
    bus(1'b1, RRU_INSTR_OFS, {16'h0, ins}, q);
    if (ins[RRU_DEST_BIT] && ins[15:10] !== 6'h3f) begin
      n = 0;
      while (file_wr.en !== 1'b1 && n < 20) begin
        @(posedge sys_clk);
        n++;
      end
      chk(n, 5);
      @(posedge sys_clk);
      chk(file_wr.en, 1'b0);
    end
    n = 0;
    do begin
      bus(1'b0, RRU_STATUS_OFS, 32'h0, q);
      n++;
    end while (q[RRU_ST_BUSY_BIT] !== 1'b0 && n < 20);
    chk(q[RRU_ST_BUSY_BIT], 1'b0);
  endtask
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    rru_row_t r;
    logic [7:0] er;
    logic [11:0] ea;
    logic [31:0] v;
    logic [31:0] es;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      er = r.res;
      ea = {(r.ins[RRU_ACC_BIT] ? 4'h5 : RRU_FAST_BANK), r.ins[7:0]};
      es = 32'h0;
      es[RRU_ST_DONE_BIT] = 1'b1;
      es[RRU_ST_CARRY_BIT] = (r.ins[15:10] === RRU_OPC_ROTATE_LEFT_NO_CARRY) ? r.ctl[0] : r.op[0];
      es[RRU_ST_NEG_BIT] = er[7];
      es[RRU_ST_ZERO_BIT] = (er == 8'h00);
      es[RRU_ST_INDEXED_BIT] = r.ctl[1] & ~r.ins[RRU_ACC_BIT] & (r.ins[7:0] <= RRU_INDEXED_LIMIT);
      bus(1'b1, RRU_CTRL_OFS, {20'h0, 4'h5, 6'h0, r.ctl}, v);
      bus(1'b1, RRU_OPND_OFS, {24'h0, r.op}, v);
      bus(1'b1, RRU_WORK_OFS, 32'h3c, v);
      run_instr(r.ins);
      bus(1'b0, RRU_RESULT_OFS, 32'h0, v);
      chk(v, {24'h0, er});
      bus(1'b0, RRU_STATUS_OFS, 32'h0, v);
      chk(v, es);
      bus(1'b0, RRU_ADDR_OFS, 32'h0, v);
      chk(v, {20'h0, ea});
      bus(1'b0, r.ins[RRU_DEST_BIT] ? RRU_OPND_OFS : RRU_WORK_OFS, 32'h0, v);
      chk(v, {24'h0, er});
      bus(1'b0, r.ins[RRU_DEST_BIT] ? RRU_WORK_OFS : RRU_OPND_OFS, 32'h0, v);
      chk(v, r.ins[RRU_DEST_BIT] ? 32'h3c : {24'h0, r.op});
      if (r.ins[RRU_DEST_BIT]) chk({12'h0, m_addr, m_data}, {12'h0, ea, er});
    end
    // Unknown opcode: flags stay, done clears and only illegal is set
    bus(1'b1, RRU_CTRL_OFS, 32'h1, v);
    run_instr({6'h3f, 2'b01, 8'h00});
    bus(1'b0, RRU_STATUS_OFS, 32'h0, v);
    chk(v, 32'h14);
    bus(1'b0, 5'h1c, 32'h0, v);
    chk(v, 32'h0);
    // Byte enables: only the bank lane of CTRL is written
    avs_byteenable <= 4'h2;
    bus(1'b1, RRU_CTRL_OFS, 32'hffff_ffff, v);
    avs_byteenable <= 4'hf;
    bus(1'b0, RRU_CTRL_OFS, 32'h0, v);
    chk(v, 32'h0000_0f01);
    // Write during an instruction stalls until idle and is not lost
    bus(1'b1, RRU_OPND_OFS, 32'h81, v);
    bus(1'b1, RRU_INSTR_OFS, {16'h0, RRU_OPC_ROTATE_LEFT_NO_CARRY, 2'b00, 8'h02}, v);
    bus(1'b1, RRU_OPND_OFS, 32'h42, v);
    bus(1'b0, RRU_WORK_OFS, 32'h0, v);
    chk(v, 32'h03);
    bus(1'b0, RRU_OPND_OFS, 32'h0, v);
    chk(v, 32'h42);
    // Reset while idle, after the last instruction, clears the registers
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      bus(1'b0, 5'(4 * k), 32'h0, v);
      chk(v, 32'h0);
    end
    chk({11'h0, file_wr}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
